// ===== hdl/tpp_defs.svh
// constants of the paired 16-bit timer block
`ifndef TPP_DEFS_SVH
`define TPP_DEFS_SVH
`define TPP_ADDR_W 6
`define TPP_OFF_CNT_LO 6'h00
`define TPP_OFF_PER_LO 6'h04
`define TPP_OFF_CTRL_LO 6'h08
`define TPP_OFF_CNT_HI 6'h0C
`define TPP_OFF_PER_HI 6'h10
`define TPP_OFF_CTRL_HI 6'h14
`define TPP_OFF_IRQ_CTL 6'h18
`define TPP_OFF_IRQ_FLAG 6'h1C
`define TPP_OFF_OSC_CTL 6'h20
`define TPP_B_RUN 15
`define TPP_B_GATE 6
`define TPP_PS_MSB 5
`define TPP_PS_LSB 4
`define TPP_B_PAIR 3
`define TPP_B_CS 1
`define TPP_B_EN_LO 0
`define TPP_PRI_LO_MSB 3
`define TPP_PRI_LO_LSB 1
`define TPP_B_EN_HI 4
`define TPP_PRI_HI_MSB 7
`define TPP_PRI_HI_LSB 5
`define TPP_B_FLAG_LO 0
`define TPP_B_FLAG_HI 1
`define TPP_B_OSC_EN 0
`define TPP_CNT_RST 16'h0000
`define TPP_PER_RST 16'hFFFF
`define TPP_CTRL_RST 16'h0000
`define TPP_PS_LIM_1 8'h00
`define TPP_PS_LIM_8 8'h07
`define TPP_PS_LIM_64 8'h3F
`define TPP_PS_LIM_256 8'hFF
`define TPP_RESP_OKAY 2'h0
`define TPP_RESP_SLVERR 2'h2
`endif

// ===== hdl/tpp_pkg.sv
// types of the paired 16-bit timer block
`include "tpp_defs.svh"
package tpp_pkg;
	typedef struct packed {
		logic [7:0] div;
	} tpp_pre_state_t;

	typedef struct packed {
		logic [15:0] cnt_lo;
		logic [15:0] cnt_hi;
		logic [15:0] per_lo;
		logic [15:0] per_hi;
		logic [15:0] ctrl_lo;
		logic [15:0] ctrl_hi;
		logic [7:0] irq_ctl;
		logic [1:0] flag;
		logic osc_en;
		logic pin_lo_q;
		logic pin_hi_q;
		logic xtal_q;
		logic aw_full;
		logic [`TPP_ADDR_W-1:0] waddr;
		logic w_full;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} tpp_state_t;
endpackage : tpp_pkg

// ===== hdl/tpp_prescale.sv
// input prescaler of one 16-bit timer
`timescale 1ns/1ps
module tpp_prescale import tpp_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// control
	input wire logic tick_in,
	input wire logic clear,
	input wire logic [1:0] sel,
	// divided tick
	output logic tick_out
);
	tpp_pre_state_t s;
	tpp_pre_state_t next_s;
	logic [7:0] limit;

	always_comb
	begin
		case (sel)
			2'h0: limit = `TPP_PS_LIM_1;
			2'h1: limit = `TPP_PS_LIM_8;
			2'h2: limit = `TPP_PS_LIM_64;
			default: limit = `TPP_PS_LIM_256;
		endcase
		// a clear in the same cycle swallows the tick, so a count write never steps
		tick_out = tick_in && !clear && (s.div == limit);
		next_s = s;
		if (clear)
			next_s.div = 8'h00;
		else if (tick_out)
			next_s.div = 8'h00;
		else if (tick_in)
			next_s.div = 8'(s.div + 8'h01);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s <= '0;
		else
			s <= next_s;
	end

	property p_ps_one_in_n;
		@(posedge aclk) disable iff (!aresetn)
		tick_out |-> (s.div == limit) && !clear;
	endproperty
	a_ps_one_in_n: assert property (p_ps_one_in_n) else $error("tick passed before divider end");

	property p_ps_clear;
		@(posedge aclk) disable iff (!aresetn)
		clear |=> (s.div == 8'h00);
	endproperty
	a_ps_clear: assert property (p_ps_clear) else $error("prescaler not cleared");
endmodule : tpp_prescale

// ===== hdl/tpp_timer_pair.sv
// two 16-bit timers that pair into one 32-bit timer, AXI4-Lite registers
`timescale 1ns/1ps
module tpp_timer_pair import tpp_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write address channel
	input wire logic awvalid,
	output logic awready,
	input wire logic [`TPP_ADDR_W-1:0] awaddr,
	// write data channel
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// write response channel
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// read address channel
	input wire logic arvalid,
	output logic arready,
	input wire logic [`TPP_ADDR_W-1:0] araddr,
	// read data channel
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// pins, sampled as synchronous levels
	input wire logic ext_pin_low,
	input wire logic ext_pin_high,
	input wire logic crystal_in_pin,
	// interrupt requests to the controller
	output logic irq_req_low,
	output logic irq_req_high,
	output logic [2:0] irq_pri_low,
	output logic [2:0] irq_pri_high
);
	tpp_state_t s;
	tpp_state_t next_s;

	// byte lanes 0 and 1 only; lanes 2 and 3 fall on read-as-zero bits
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		logic [15:0] r;
		r = old;
		if (strb[0])
			r[7:0] = d[7:0];
		if (strb[1])
			r[15:8] = d[15:8];
		return r;
	endfunction : merge16

	function automatic logic [15:0] step16(input logic [15:0] c, input logic [15:0] p);
		return (c == p) ? `TPP_CNT_RST : 16'(c + 16'h0001);
	endfunction : step16

	logic wr_go;
	logic [`TPP_ADDR_W-1:0] wa;
	logic wr_lanes;
	logic wr_cnt_lo, wr_cnt_hi, wr_ctrl_lo, wr_flag;
	logic pair, run_lo, run_hi;
	logic gate_lo, gate_hi;
	logic src_lo, src_hi, raw_lo, raw_hi;
	logic tick_lo, tick_hi;
	logic fall_lo, fall_hi;
	logic [31:0] c32, p32;
	logic match_lo, match_hi, match32;
	logic set_lo, set_hi;
	logic [15:0] rd_word;
	logic rd_hit;
	logic [1:0] flag_wr;

	assign pair = s.ctrl_lo[`TPP_B_PAIR];
	assign run_lo = s.ctrl_lo[`TPP_B_RUN];
	// high control is don't-care while paired
	assign run_hi = s.ctrl_hi[`TPP_B_RUN] && !pair;
	assign gate_lo = s.ctrl_lo[`TPP_B_GATE] && !s.ctrl_lo[`TPP_B_CS] && run_lo;
	assign gate_hi = s.ctrl_hi[`TPP_B_GATE] && !s.ctrl_hi[`TPP_B_CS] && run_hi;
	// crystal edges replace the low timer's pin when the oscillator is enabled; the high timer keeps ext_pin_high
	assign src_lo = s.osc_en ? (crystal_in_pin && !s.xtal_q)
		: (ext_pin_low && !s.pin_lo_q);
	assign src_hi = ext_pin_high && !s.pin_hi_q;
	// pin clock sources are edge-sampled on aclk, the gate passes the pin level; no asynchronous path exists
	assign raw_lo = run_lo && (s.ctrl_lo[`TPP_B_CS] ? src_lo
		: (gate_lo ? ext_pin_low : 1'h1));
	assign raw_hi = run_hi && (s.ctrl_hi[`TPP_B_CS] ? src_hi
		: (gate_hi ? ext_pin_high : 1'h1));
	assign fall_lo = gate_lo && s.pin_lo_q && !ext_pin_low;
	assign fall_hi = gate_hi && s.pin_hi_q && !ext_pin_high;

	assign wr_go = s.aw_full && s.w_full && !s.bvalid;
	assign wa = {s.waddr[`TPP_ADDR_W-1:2], 2'h0};
	assign wr_lanes = wr_go && (s.wstrb[1:0] != 2'h0);
	assign wr_cnt_lo = wr_lanes && (wa == `TPP_OFF_CNT_LO);
	assign wr_cnt_hi = wr_lanes && (wa == `TPP_OFF_CNT_HI);
	assign wr_ctrl_lo = wr_lanes && (wa == `TPP_OFF_CTRL_LO);
	assign wr_flag = wr_lanes && (wa == `TPP_OFF_IRQ_FLAG);

	tpp_prescale u_pre_lo (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick_in(raw_lo),
		.clear(wr_cnt_lo || !run_lo),
		.sel(s.ctrl_lo[`TPP_PS_MSB:`TPP_PS_LSB]),
		.tick_out(tick_lo)
	);

	tpp_prescale u_pre_hi (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick_in(raw_hi),
		.clear(wr_cnt_hi || !run_hi),
		.sel(s.ctrl_hi[`TPP_PS_MSB:`TPP_PS_LSB]),
		.tick_out(tick_hi)
	);

	assign c32 = {s.cnt_hi, s.cnt_lo};
	assign p32 = {s.per_hi, s.per_lo};
	// a zero period never flags, so a stalled-at-zero timer stays quiet
	assign match_lo = tick_lo && !pair && !gate_lo && (s.cnt_lo == s.per_lo)
		&& (s.per_lo != 16'h0000);
	assign match_hi = tick_hi && !gate_hi && (s.cnt_hi == s.per_hi)
		&& (s.per_hi != 16'h0000);
	assign match32 = tick_lo && pair && !gate_lo && (c32 == p32)
		&& (p32 != 32'h00000000);
	// pair events land on the high-word flag only
	assign set_lo = !pair && (match_lo || fall_lo);
	assign set_hi = match_hi || match32 || (pair && fall_lo) || fall_hi;

	always_comb
	begin
		rd_hit = 1'h1;
		case ({araddr[`TPP_ADDR_W-1:2], 2'h0})
			`TPP_OFF_CNT_LO: rd_word = s.cnt_lo;
			`TPP_OFF_PER_LO: rd_word = s.per_lo;
			`TPP_OFF_CTRL_LO: rd_word = s.ctrl_lo;
			`TPP_OFF_CNT_HI: rd_word = s.cnt_hi;
			`TPP_OFF_PER_HI: rd_word = s.per_hi;
			`TPP_OFF_CTRL_HI: rd_word = s.ctrl_hi;
			`TPP_OFF_IRQ_CTL: rd_word = {8'h00, s.irq_ctl};
			`TPP_OFF_IRQ_FLAG: rd_word = {14'h0000, s.flag};
			`TPP_OFF_OSC_CTL: rd_word = {15'h0000, s.osc_en};
			default:
			begin
				rd_word = 16'h0000;
				rd_hit = 1'h0;
			end
		endcase
	end

	always_comb
	begin
		next_s = s;
		flag_wr = 2'(merge16({14'h0000, s.flag}, s.wdata, s.wstrb));
		next_s.pin_lo_q = ext_pin_low;
		next_s.pin_hi_q = ext_pin_high;
		next_s.xtal_q = crystal_in_pin;
		// counting; a pending count write masks this cycle's step
		if (pair)
		begin
			if (tick_lo && !wr_cnt_lo && !wr_cnt_hi)
			begin
				if (c32 == p32)
				begin
					next_s.cnt_lo = `TPP_CNT_RST;
					next_s.cnt_hi = `TPP_CNT_RST;
				end
				else
				begin
					next_s.cnt_lo = 16'(c32[15:0] + 16'h0001);
					next_s.cnt_hi = 16'(c32[31:16] + 16'(s.cnt_lo == 16'hFFFF));
				end
			end
		end
		else
		begin
			if (tick_lo)
				next_s.cnt_lo = step16(s.cnt_lo, s.per_lo);
			if (tick_hi)
				next_s.cnt_hi = step16(s.cnt_hi, s.per_hi);
		end
		// register writes; only lanes written change, the rest keep their old value
		if (wr_cnt_lo)
			next_s.cnt_lo = merge16(s.cnt_lo, s.wdata, s.wstrb);
		if (wr_cnt_hi)
			next_s.cnt_hi = merge16(s.cnt_hi, s.wdata, s.wstrb);
		if (wr_lanes && (wa == `TPP_OFF_PER_LO))
			next_s.per_lo = merge16(s.per_lo, s.wdata, s.wstrb);
		if (wr_lanes && (wa == `TPP_OFF_PER_HI))
			next_s.per_hi = merge16(s.per_hi, s.wdata, s.wstrb);
		if (wr_ctrl_lo)
			next_s.ctrl_lo = merge16(s.ctrl_lo, s.wdata, s.wstrb);
		if (wr_lanes && (wa == `TPP_OFF_CTRL_HI))
			next_s.ctrl_hi = merge16(s.ctrl_hi, s.wdata, s.wstrb);
		if (wr_go && s.wstrb[0] && (wa == `TPP_OFF_IRQ_CTL))
			next_s.irq_ctl = s.wdata[7:0];
		if (wr_go && s.wstrb[0] && (wa == `TPP_OFF_OSC_CTL))
			next_s.osc_en = s.wdata[`TPP_B_OSC_EN];
		// software clears flags; a same-cycle event still wins
		if (wr_flag)
			next_s.flag = flag_wr;
		next_s.flag[`TPP_B_FLAG_LO] = next_s.flag[`TPP_B_FLAG_LO] || set_lo;
		next_s.flag[`TPP_B_FLAG_HI] = next_s.flag[`TPP_B_FLAG_HI] || set_hi;
		// write channels, taken in either order
		if (awvalid && awready)
		begin
			next_s.aw_full = 1'h1;
			next_s.waddr = awaddr;
		end
		if (wvalid && wready)
		begin
			next_s.w_full = 1'h1;
			next_s.wdata = wdata;
			next_s.wstrb = wstrb;
		end
		if (wr_go)
		begin
			next_s.aw_full = 1'h0;
			next_s.w_full = 1'h0;
			next_s.bvalid = 1'h1;
			next_s.bresp = (wa > `TPP_OFF_OSC_CTL) ? `TPP_RESP_SLVERR : `TPP_RESP_OKAY;
		end
		else if (s.bvalid && bready)
			next_s.bvalid = 1'h0;
		// read channel; a non-word address reads as zero
		if (arvalid && arready)
		begin
			next_s.rvalid = 1'h1;
			next_s.rdata = (araddr[1:0] != 2'h0) ? 32'h00000000 : {16'h0000, rd_word};
			next_s.rresp = rd_hit ? `TPP_RESP_OKAY : `TPP_RESP_SLVERR;
		end
		else if (s.rvalid && rready)
			next_s.rvalid = 1'h0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s <= '0;
			s.per_lo <= `TPP_PER_RST;
			s.per_hi <= `TPP_PER_RST;
			s.ctrl_lo <= `TPP_CTRL_RST;
			s.ctrl_hi <= `TPP_CTRL_RST;
			s.cnt_lo <= `TPP_CNT_RST;
			s.cnt_hi <= `TPP_CNT_RST;
		end
		else
			s <= next_s;
	end

	assign awready = !s.aw_full;
	assign wready = !s.w_full;
	assign arready = !s.rvalid;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign rvalid = s.rvalid;
	assign rdata = s.rdata;
	assign rresp = s.rresp;
	// in pair mode irq_req_low is held low; irq_pri_low still shows the low-word priority bits
	assign irq_pri_low = s.irq_ctl[`TPP_PRI_LO_MSB:`TPP_PRI_LO_LSB];
	assign irq_pri_high = s.irq_ctl[`TPP_PRI_HI_MSB:`TPP_PRI_HI_LSB];
	assign irq_req_low = !pair && s.flag[`TPP_B_FLAG_LO] && s.irq_ctl[`TPP_B_EN_LO]
		&& (irq_pri_low != 3'h0);
	assign irq_req_high = s.flag[`TPP_B_FLAG_HI] && s.irq_ctl[`TPP_B_EN_HI]
		&& (irq_pri_high != 3'h0);

	property p_cnt_write;
		@(posedge aclk) disable iff (!aresetn)
		(wr_cnt_lo && s.wstrb[1:0] == 2'h3) |=> (s.cnt_lo == $past(s.wdata[15:0]));
	endproperty
	a_cnt_write: assert property (p_cnt_write) else $error("count write lost");

	property p_ctrl_keeps_cnt;
		@(posedge aclk) disable iff (!aresetn)
		(wr_ctrl_lo && !wr_cnt_lo && !tick_lo) |=> (s.cnt_lo == $past(s.cnt_lo));
	endproperty
	a_ctrl_keeps_cnt: assert property (p_ctrl_keeps_cnt) else $error("control write moved count");

	property p_stopped_holds;
		@(posedge aclk) disable iff (!aresetn)
		(!run_lo && !wr_cnt_lo && !wr_cnt_hi) |=> $stable(s.cnt_lo) && !$rose(s.flag[0]);
	endproperty
	a_stopped_holds: assert property (p_stopped_holds) else $error("stopped timer moved");

	property p_zero_period;
		@(posedge aclk) disable iff (!aresetn)
		(!pair && !gate_lo && s.per_lo == 16'h0000 && !s.flag[0]) |=> !s.flag[0];
	endproperty
	a_zero_period: assert property (p_zero_period) else $error("zero period flagged");

	property p_flag_sticky;
		@(posedge aclk) disable iff (!aresetn)
		(s.flag[1] && !wr_flag) |=> s.flag[1];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared by hardware");

	property p_irq_gate;
		@(posedge aclk) disable iff (!aresetn)
		irq_req_high |-> s.irq_ctl[`TPP_B_EN_HI] && irq_pri_high != 3'h0 && s.flag[1];
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("request without enable");

	property p_gate_fall;
		@(posedge aclk) disable iff (!aresetn)
		(gate_lo && $fell(ext_pin_low)) |=> (pair ? s.flag[1] : s.flag[0]);
	endproperty
	a_gate_fall: assert property (p_gate_fall) else $error("gate fall not flagged");

	property p_carry;
		@(posedge aclk) disable iff (!aresetn)
		(pair && tick_lo && c32 != p32 && s.cnt_lo == 16'hFFFF && !wr_cnt_lo && !wr_cnt_hi)
		|=> (s.cnt_hi == 16'($past(s.cnt_hi) + 16'h0001)) && s.cnt_lo == 16'h0000;
	endproperty
	a_carry: assert property (p_carry) else $error("high word missed carry");

	property p_byte_read;
		@(posedge aclk) disable iff (!aresetn)
		(arvalid && arready && araddr[1:0] != 2'h0) |=> rvalid && rdata == 32'h00000000;
	endproperty
	a_byte_read: assert property (p_byte_read) else $error("byte read returned data");
endmodule : tpp_timer_pair

// ===== test/tpp_pin_model.sv
// behavioural model of the clock, gate and crystal pins at the timer's far side
`timescale 1ns/1ps
module tpp_pin_model
(
	// clock
	input wire logic aclk,
	// burst command from the bench
	input wire logic req,
	input wire logic [1:0] pin_sel,
	input wire logic [8:0] pulses,
	input wire logic [3:0] half,
	input wire logic [2:0] hold,
	output logic busy,
	// pins
	output logic ext_pin_low,
	output logic ext_pin_high,
	output logic crystal_in_pin
);
	logic [2:0] lvl;
	int i;
	// clock pins stand still between bursts; hold gives a steady gate level
	assign ext_pin_low = lvl[0] | hold[0];
	assign ext_pin_high = lvl[1] | hold[1];
	assign crystal_in_pin = lvl[2] | hold[2];
	initial
	begin
		lvl = 3'h0;
		busy = 1'b0;
		forever
		begin
			@(posedge aclk);
			if (req)
			begin
				busy <= 1'b1;
				// half sets the pace: 1 is as fast as the pin logic allows
				for (i = 0; i < pulses; i++)
				begin
					repeat (half) @(posedge aclk);
					lvl[pin_sel] <= 1'b1;
					repeat (half) @(posedge aclk);
					lvl[pin_sel] <= 1'b0;
				end
				@(posedge aclk);
				busy <= 1'b0;
			end
		end
	end
endmodule : tpp_pin_model

// ===== test/tpp_timer_pair_test.sv
// self-checking bench of the paired timer through its AXI4-Lite registers
`timescale 1ns/1ps
`include "tpp_defs.svh"
module tpp_timer_pair_test;
	localparam logic [5:0] a_cl = `TPP_OFF_CNT_LO;
	localparam logic [5:0] a_pl = `TPP_OFF_PER_LO;
	localparam logic [5:0] a_tl = `TPP_OFF_CTRL_LO;
	localparam logic [5:0] a_ch = `TPP_OFF_CNT_HI;
	localparam logic [5:0] a_ph = `TPP_OFF_PER_HI;
	localparam logic [5:0] a_ic = `TPP_OFF_IRQ_CTL;
	localparam logic [5:0] a_fl = `TPP_OFF_IRQ_FLAG;
	logic aclk;
	logic aresetn;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [`TPP_ADDR_W-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata, v0, v1;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, p_sel;
	logic pin_lo, pin_hi, pin_x, irq_lo, irq_hi, p_req, p_busy;
	logic [2:0] pri_lo, pri_hi, p_hold;
	logic [8:0] p_cnt;
	logic [3:0] p_half;
	int err_total, n_checks;
	int divs[4] = '{1, 8, 64, 256};

	tpp_timer_pair u_tpp_timer_pair (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
		.wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
		.rresp(rresp), .ext_pin_low(pin_lo), .ext_pin_high(pin_hi), .crystal_in_pin(pin_x),
		.irq_req_low(irq_lo), .irq_req_high(irq_hi), .irq_pri_low(pri_lo),
		.irq_pri_high(pri_hi));
	tpp_pin_model u_tpp_pin_model (.aclk(aclk), .req(p_req), .pin_sel(p_sel), .pulses(p_cnt),
		.half(p_half), .hold(p_hold), .busy(p_busy), .ext_pin_low(pin_lo),
		.ext_pin_high(pin_hi), .crystal_in_pin(pin_x));

	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : stop_test

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic guard(input logic hit);
		if (hit)
		begin
			err_total++;
			$display("mismatch wait bound expected done seen hang");
			stop_test();
		end
	endtask : guard

	// unmapped offsets answer with an error code, mapped ones with okay
	function automatic logic [31:0] resp_of(input logic [5:0] a);
		return (a > `TPP_OFF_OSC_CTL) ? {30'h0, `TPP_RESP_SLVERR} : {30'h0, `TPP_RESP_OKAY};
	endfunction : resp_of

	task automatic wr(input logic [5:0] a, input logic [31:0] dv, input logic [3:0] s);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= dv;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end
		while (!bvalid && n < 100);
		chk("write response", resp_of(a), {30'h0, bresp});
		guard(n >= 100);
	endtask : wr

	task automatic rd(input logic [5:0] a, output logic [31:0] v);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (arvalid && arready)
				arvalid <= 1'b0;
		end
		while (!rvalid && n < 100);
		v = rdata;
		chk("read response", resp_of(a), {30'h0, rresp});
		guard(n >= 100);
	endtask : rd

	task automatic rc(input logic [5:0] a, input logic [31:0] e, input string nm);
		logic [31:0] v;
		rd(a, v);
		chk(nm, e, v);
	endtask : rc

	// pins settle through one sampling register, so wait a few edges after a burst
	task automatic pulse(input logic [1:0] s, input int n, input int h);
		int k;
		k = 0;
		p_sel <= s;
		p_cnt <= n[8:0];
		p_half <= h[3:0];
		p_req <= 1'b1;
		@(posedge aclk);
		p_req <= 1'b0;
		repeat (2) @(posedge aclk);
		while (p_busy && k < 5000)
		begin
			@(posedge aclk);
			k++;
		end
		guard(k >= 5000);
		repeat (3) @(posedge aclk);
	endtask : pulse

	initial
	begin
		err_total = 0;
		n_checks = 0;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, p_req} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{p_sel, p_cnt, p_half, p_hold} = '0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rc(a_cl, 32'h0, "count reset");
		rc(a_ph, 32'hFFFF, "period reset");
		rc(a_tl, 32'h0, "control reset");
		rc(6'h01, 32'h0, "byte read");
		rc(6'h24, 32'h0, "unmapped read");
		wr(6'h24, 32'hFFFF, 4'hF);
		$display("test reset done");
		wr(a_cl, 32'h1234, 4'h3);
		wr(a_cl, 32'h00FF, 4'h1);
		rc(a_cl, 32'h12FF, "low byte write");
		wr(a_cl, 32'hAB00, 4'h2);
		rc(a_cl, 32'hABFF, "high byte write");
		wr(a_tl, 32'h8002, 4'h3);
		rc(a_cl, 32'hABFF, "count after control write");
		pulse(2'h0, 1, 3);
		rc(a_cl, 32'hAC00, "byte carry");
		wr(a_tl, 32'h0, 4'h3);
		pulse(2'h0, 2, 3);
		rc(a_cl, 32'hAC00, "stopped count");
		$display("test byte access done");
		for (int s = 0; s < 4; s++)
		begin
			wr(a_tl, 32'h8002 | (s << 4), 4'h3);
			pulse(2'h0, 3, 1);
			wr(a_cl, 32'h0, 4'h3);
			pulse(2'h0, divs[s] - 1, 1);
			rc(a_cl, 32'h0, "prescale short");
			pulse(2'h0, 1, 1);
			rc(a_cl, 32'h1, "prescale full");
		end
		$display("test prescaler done");
		wr(a_tl, 32'h0, 4'h3);
		wr(a_cl, 32'h0, 4'h3);
		wr(a_pl, 32'h3, 4'h3);
		wr(a_ic, 32'h3, 4'h1);
		wr(a_tl, 32'h8002, 4'h3);
		pulse(2'h0, 3, 2);
		rc(a_fl, 32'h0, "flag before match");
		pulse(2'h0, 1, 2);
		rc(a_cl, 32'h0, "count after match");
		rc(a_fl, 32'h1, "flag on match");
		chk("irq low", 32'h1, {31'h0, irq_lo});
		chk("priority low", 32'h1, {29'h0, pri_lo});
		wr(a_ic, 32'h1, 4'h1);
		pulse(2'h0, 2, 2);
		chk("irq low zero priority", 32'h0, {31'h0, irq_lo});
		rc(a_fl, 32'h1, "flag held");
		wr(a_fl, 32'h0, 4'h1);
		wr(a_pl, 32'h0, 4'h3);
		wr(a_cl, 32'h0, 4'h3);
		pulse(2'h0, 4, 2);
		rc(a_fl, 32'h0, "flag zero period");
		$display("test match done");
		wr(a_tl, 32'h0, 4'h3);
		wr(a_cl, 32'h0, 4'h3);
		wr(a_pl, 32'h2, 4'h3);
		wr(a_tl, 32'h8040, 4'h3);
		rc(a_cl, 32'h0, "gate low holds");
		p_hold <= 3'h1;
		repeat (10) @(posedge aclk);
		rc(a_fl, 32'h0, "no flag gated match");
		p_hold <= 3'h0;
		repeat (4) @(posedge aclk);
		rc(a_fl, 32'h1, "flag gate fall");
		rd(a_cl, v0);
		repeat (5) @(posedge aclk);
		rd(a_cl, v1);
		chk("count after gate fall", v0, v1);
		$display("test gated done");
		wr(a_tl, 32'h0, 4'h3);
		wr(a_fl, 32'h0, 4'h1);
		wr(a_pl, 32'hFFFF, 4'h3);
		wr(`TPP_OFF_CTRL_HI, 32'h8032, 4'h3);
		wr(a_ic, 32'h33, 4'h1);
		wr(a_cl, 32'hFFFE, 4'h3);
		wr(a_ch, 32'h0, 4'h3);
		wr(a_tl, 32'h800A, 4'h3);
		pulse(2'h0, 2, 2);
		rc(a_cl, 32'h0, "pair low word");
		rc(a_ch, 32'h1, "pair high word");
		pulse(2'h1, 3, 2);
		rc(a_ch, 32'h1, "high pin ignored");
		wr(a_ph, 32'h1, 4'h3);
		wr(a_pl, 32'h3, 4'h3);
		pulse(2'h0, 3, 2);
		rc(a_fl, 32'h0, "pair flag early");
		pulse(2'h0, 1, 2);
		rc(a_ch, 32'h0, "pair roll over");
		rc(a_fl, 32'h2, "pair flag");
		chk("irq high", 32'h1, {31'h0, irq_hi});
		chk("priority high", 32'h1, {29'h0, pri_hi});
		chk("irq low in pair", 32'h0, {31'h0, irq_lo});
		$display("test pair done");
		wr(a_tl, 32'h0, 4'h3);
		wr(`TPP_OFF_OSC_CTL, 32'h1, 4'h1);
		wr(a_cl, 32'h0, 4'h3);
		wr(a_pl, 32'hFFFF, 4'h3);
		wr(a_tl, 32'h8002, 4'h3);
		pulse(2'h0, 2, 2);
		pulse(2'h2, 2, 2);
		rc(a_cl, 32'h2, "crystal clock");
		wr(a_tl, 32'h8000, 4'h3);
		rd(a_cl, v0);
		rd(a_cl, v1);
		chk("count runs across reads", 32'h1, {31'h0, v1 > v0});
		wr(a_cl, 32'h0100, 4'h3);
		rd(a_cl, v0);
		chk("write while running", 32'h1, {31'h0, v0 >= 32'h100 && v0 < 32'h120});
		$display("test crystal and run done");
		stop_test();
	end
endmodule : tpp_timer_pair_test
